// ---- rtl/tse_core.sv ----
// status flags and software event generation of an advanced timer, AXI4-Lite slave
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/1ps
module tse_core (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic break_active_i,
  input wire logic slave_trigger_input_i,
  input wire logic slave_enable_i,
  input wire logic gated_mode_i,
  input wire logic trigger_reinit_i,
  input wire logic commutation_event_i,
  input wire logic counter_wrap_i,
  input wire logic center_align_select_i,
  input wire logic center_match_allow_i,
  input wire logic rep_zero_i,
  input wire logic [15:0] counter_value_i,
  input wire logic [15:0] auto_reload_value_i,
  input wire logic [63:0] chan_compare_value_i,
  input wire logic [3:0] capture_event_i,
  input wire logic [3:0] capture_read_i,
  output logic main_output_enable_clr_o,
  output logic update_force_o,
  output logic counter_load_o,
  output logic [15:0] counter_load_value_o,
  output logic prescaler_clear_o,
  output logic commutation_apply_o,
  output logic [3:0] chan_capture_strobe_o,
  output logic [31:0] irq_enable_o,
  output logic irq_o,
  output logic [6:0] dma_req_o
);
  import tse_pkg::*;

  logic [31:0] flags;
  logic [31:0] irq_en;
  logic [7:0] cfg;
  logic [7:0] force_evt;
  logic [2:0] brk_sync;
  logic [2:0] trg_sync;
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic [31:0] cfg_merged;

  function automatic logic [31:0] lane_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // write channel: address and data taken independently, response after both
  assign s_axi_awready_o = !aw_held && !s_axi_bvalid_o;
  assign s_axi_wready_o = !w_held && !s_axi_bvalid_o;
  wire aw_take = s_axi_awvalid_i && s_axi_awready_o;
  wire w_take = s_axi_wvalid_i && s_axi_wready_o;
  wire have_aw = aw_held || aw_take;
  wire have_w = w_held || w_take;
  wire do_write = have_aw && have_w && !s_axi_bvalid_o;
  wire [7:0] wr_addr = aw_held ? aw_addr : s_axi_awaddr_i;
  wire [31:0] wr_data = w_held ? w_data : s_axi_wdata_i;
  wire [3:0] wr_strb = w_held ? w_strb : s_axi_wstrb_i;
  wire wr_flags = do_write && (wr_addr == TSE_FLAGS_OFF);
  wire wr_trig = do_write && (wr_addr == TSE_TRIG_OFF);
  wire wr_irqen = do_write && (wr_addr == TSE_IRQEN_OFF);
  wire wr_cfg = do_write && (wr_addr == TSE_CFG_OFF);
  wire wr_hit = wr_flags || wr_trig || wr_irqen || wr_cfg;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= TSE_RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_addr <= s_axi_awaddr_i;
      end
      if (w_take) begin
        w_data <= s_axi_wdata_i;
        w_strb <= s_axi_wstrb_i;
      end
      aw_held <= have_aw && !do_write;
      w_held <= have_w && !do_write;
      if (do_write) begin
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o <= wr_hit ? TSE_RESP_OKAY : TSE_RESP_SLVERR;
      end else if (s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
      end
    end
  end

  // read channel: one cycle latency; event register reads as zero
  assign s_axi_arready_o = !s_axi_rvalid_o;
  wire ar_take = s_axi_arvalid_i && s_axi_arready_o;
  wire rd_flags = s_axi_araddr_i == TSE_FLAGS_OFF;
  wire rd_trig = s_axi_araddr_i == TSE_TRIG_OFF;
  wire rd_irqen = s_axi_araddr_i == TSE_IRQEN_OFF;
  wire rd_cfg = s_axi_araddr_i == TSE_CFG_OFF;
  wire rd_hit = rd_flags || rd_trig || rd_irqen || rd_cfg;
  wire [31:0] rd_mux = rd_flags ? (flags & TSE_FLAGS_MASK) :
                       rd_irqen ? irq_en :
                       rd_cfg ? {24'h00_0000, cfg} : 32'h0000_0000;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h0000_0000;
      s_axi_rresp_o <= TSE_RESP_OKAY;
    end else if (ar_take) begin
      s_axi_rvalid_o <= 1'b1;
      s_axi_rdata_o <= rd_mux;
      s_axi_rresp_o <= rd_hit ? TSE_RESP_OKAY : TSE_RESP_SLVERR;
    end else if (s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'b0;
    end
  end

  // pin synchronisers; stage 0 feeds only stage 1
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      brk_sync <= 3'b000;
      trg_sync <= 3'b000;
    end else begin
      brk_sync <= {brk_sync[1:0], break_active_i};
      trg_sync <= {trg_sync[1:0], slave_trigger_input_i};
    end
  end
  wire brk_level = brk_sync[1];
  wire trg_rise = trg_sync[1] && !trg_sync[2];
  wire trg_fall = !trg_sync[1] && trg_sync[2];

  // event pulses: forced bits act one cycle after the write and then vanish
  wire [31:0] trig_merged = lane_merge(32'h0000_0000, wr_data, wr_strb);
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      force_evt <= 8'h00;
    end else begin
      force_evt <= wr_trig ? trig_merged[7:0] : 8'h00;
    end
  end

  wire updis = cfg[TSE_CFG_UPDATE_DISABLE];
  wire update_request_source = cfg[TSE_CFG_URS];
  wire [3:0] chan_input = cfg[TSE_CFG_INPUT +: 4];
  wire force_upd = force_evt[TSE_UPD_BIT];
  wire force_com = force_evt[TSE_COM_BIT] && cfg[TSE_CFG_CPC];
  wire force_trg = force_evt[TSE_TRG_BIT];
  wire force_brk = force_evt[TSE_BRK_BIT];
  wire [3:0] force_ch = force_evt[TSE_CH_BIT +: 4];

  wire set_upd = (counter_wrap_i && rep_zero_i && !updis) ||
                 (force_upd && !update_request_source && !updis) ||
                 (trigger_reinit_i && !update_request_source && !updis);
  wire set_trg = (slave_enable_i && (trg_rise || (gated_mode_i && trg_fall))) ||
                 force_trg;
  wire set_com = commutation_event_i || force_com;
  wire set_brk = brk_level || force_brk;

  logic [3:0] set_cc;
  logic [3:0] set_ov;
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_chan
      wire [15:0] cmp = chan_compare_value_i[g*16 +: 16];
      wire over = cmp > auto_reload_value_i;
      wire eq_hit = (counter_value_i == cmp) &&
                    (!center_align_select_i || center_match_allow_i);
      wire out_set = !chan_input[g] && ((!over && eq_hit) || (over && counter_wrap_i) ||
                     force_ch[g]);
      wire in_cap = chan_input[g] && (capture_event_i[g] || force_ch[g]);
      assign set_cc[g] = out_set || in_cap;
      assign set_ov[g] = in_cap && flags[TSE_CH_BIT + g];
    end
  endgenerate

  // software clear mask: a zero written in an enabled lane clears (not the break bit while break is active), ones keep
  wire [31:0] keep_w = lane_merge(32'hffff_ffff, wr_data, wr_strb);
  logic [31:0] clr_mask;
  always_comb begin
    clr_mask = wr_flags ? ~keep_w : 32'h0000_0000;
    clr_mask[TSE_BRK_BIT] = clr_mask[TSE_BRK_BIT] && !brk_level;
    for (int i = 0; i < 4; i++) begin
      clr_mask[TSE_CH_BIT + i] = clr_mask[TSE_CH_BIT + i] ||
                                 (chan_input[i] && capture_read_i[i]);
    end
  end
  wire [31:0] set_mask = {19'h0_0000, set_ov, 1'b0, set_brk, set_trg, set_com, set_cc, set_upd};
  // set beats clear so an event landing on a clear is kept
  wire [31:0] next_flags = ((flags & ~clr_mask) | set_mask) & TSE_FLAGS_MASK;
  assign cfg_merged = lane_merge({24'h00_0000, cfg}, wr_data, wr_strb);

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      flags <= TSE_FLAGS_RST;
      irq_en <= 32'h0000_0000;
      cfg <= 8'h00;
    end else begin
      flags <= next_flags;
      if (wr_irqen) begin
        irq_en <= lane_merge(irq_en, wr_data, wr_strb) & TSE_IRQEN_MASK;
      end
      if (wr_cfg) begin
        cfg <= cfg_merged[7:0];
      end
    end
  end

  // downstream strobes, registered so they line up with the flag change
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      main_output_enable_clr_o <= 1'b0;
      update_force_o <= 1'b0;
      counter_load_o <= 1'b0;
      counter_load_value_o <= 16'h0000;
      prescaler_clear_o <= 1'b0;
      commutation_apply_o <= 1'b0;
      chan_capture_strobe_o <= 4'h0;
    end else begin
      main_output_enable_clr_o <= force_brk;
      update_force_o <= force_upd;
      counter_load_o <= force_upd;
      counter_load_value_o <= (center_align_select_i || !cfg[TSE_CFG_DIR]) ? 16'h0000 :
                              auto_reload_value_i;
      prescaler_clear_o <= force_upd;
      commutation_apply_o <= force_com;
      chan_capture_strobe_o <= force_ch & chan_input;
    end
  end

  assign irq_enable_o = irq_en;
  assign irq_o = |(flags[7:0] & irq_en[7:0]);
  assign dma_req_o = flags[6:0] & irq_en[TSE_DMA_BIT +: 7];
endmodule // tse_core

// ---- rtl/tse_pkg.sv ----
// constants for the timer status and event generation block
package tse_pkg;
  localparam logic [7:0] TSE_FLAGS_OFF = 8'h10;
  localparam logic [7:0] TSE_TRIG_OFF = 8'h14;
  localparam logic [7:0] TSE_IRQEN_OFF = 8'h0C;
  localparam logic [7:0] TSE_CFG_OFF = 8'h20;
  localparam logic [31:0] TSE_FLAGS_RST = 32'h0000_0000;
  localparam logic [31:0] TSE_FLAGS_MASK = 32'h0000_1eff;
  localparam logic [31:0] TSE_IRQEN_MASK = 32'h0000_7fff;
  localparam logic [31:0] TSE_CFG_MASK = 32'h0000_00ff;
  localparam int TSE_UPD_BIT = 0;
  localparam int TSE_CH_BIT = 1;
  localparam int TSE_COM_BIT = 5;
  localparam int TSE_TRG_BIT = 6;
  localparam int TSE_BRK_BIT = 7;
  localparam int TSE_OVC_BIT = 9;
  localparam int TSE_DMA_BIT = 8;
  localparam int TSE_CFG_URS = 0;
  localparam int TSE_CFG_UPDATE_DISABLE = 1;
  localparam int TSE_CFG_DIR = 2;
  localparam int TSE_CFG_CPC = 3;
  localparam int TSE_CFG_INPUT = 4;
  localparam logic [1:0] TSE_RESP_OKAY = 2'b00;
  localparam logic [1:0] TSE_RESP_SLVERR = 2'b10;
endpackage

// ---- testbench/tse_core_tb_top.sv ----
// self-checking testbench for the timer status and event block
`timescale 1ns/1ps
module tse_core_tb_top;
  import tse_pkg::*;
  logic clk_i = 0, rst_i = 1, s_axi_awvalid_i = 0, s_axi_wvalid_i = 0, s_axi_bready_i = 0;
  logic s_axi_arvalid_i = 0, s_axi_rready_i = 0, break_active_i = 0, slave_trigger_input_i = 0;
  logic slave_enable_i = 0, gated_mode_i = 0, trigger_reinit_i = 0, commutation_event_i = 0;
  logic counter_wrap_i = 0, center_align_select_i = 0, center_match_allow_i = 0, rep_zero_i = 0;
  logic [7:0] s_axi_awaddr_i = 0, s_axi_araddr_i = 0;
  logic [31:0] s_axi_wdata_i = 0, rd_q, s_axi_rdata_o, irq_enable_o;
  logic [3:0] s_axi_wstrb_i = 4'hf, capture_event_i = 0, capture_read_i = 0, chan_capture_strobe_o;
  logic [15:0] counter_value_i = 0, auto_reload_value_i = 16'h00ff, counter_load_value_o;
  logic [63:0] chan_compare_value_i = 64'h0300_0200_0100_0005;
  logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o, irq_o;
  logic main_output_enable_clr_o, update_force_o, counter_load_o, prescaler_clear_o;
  logic commutation_apply_o;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o, resp_q;
  logic [6:0] dma_req_o;
  int errors = 0, compares = 0, cycles = 0;
  tse_core i_dut (.*);
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      complete_run;
    end
  end
  task automatic complete_run;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // handshakes judged at the rising edge, before the design's own updates land
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic tb;
    @(posedge clk_i);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= d;
    s_axi_awvalid_i <= 1;
    s_axi_wvalid_i <= 1;
    s_axi_bready_i <= 1;
    tb = 0;
    while (!tb) begin
      @(posedge clk_i);
      tb = s_axi_bvalid_o;
      resp_q = s_axi_bresp_o;
      if (s_axi_awvalid_i && s_axi_awready_o) s_axi_awvalid_i <= 0;
      if (s_axi_wvalid_i && s_axi_wready_o) s_axi_wvalid_i <= 0;
    end
    s_axi_bready_i <= 0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    logic tr;
    @(posedge clk_i);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1;
    s_axi_rready_i <= 1;
    tr = 0;
    while (!tr) begin
      @(posedge clk_i);
      tr = s_axi_rvalid_o;
      rd_q = s_axi_rdata_o;
      resp_q = s_axi_rresp_o;
      if (s_axi_arvalid_i && s_axi_arready_o) s_axi_arvalid_i <= 0;
    end
    s_axi_rready_i <= 0;
    chk(rd_q, e);
  endtask
  task automatic s_update;
    rc(TSE_FLAGS_OFF, TSE_FLAGS_RST);
    rc(8'h40, 0);
    chk({30'h0, resp_q}, {30'h0, TSE_RESP_SLVERR});
    wr(TSE_IRQEN_OFF, 32'hffff_ffff);
    rc(TSE_IRQEN_OFF, TSE_IRQEN_MASK);
    wr(TSE_CFG_OFF, 32'h0000_0004);
    wr(TSE_TRIG_OFF, 32'h0000_0001);
    rc(TSE_TRIG_OFF, 0);
    chk({16'h0, counter_load_value_o}, 32'h0000_00ff);
    rc(TSE_FLAGS_OFF, 1);
    chk({31'h0, irq_o}, 1);
    chk({25'h0, dma_req_o}, 1);
    wr(TSE_FLAGS_OFF, 32'hffff_ffff);
    rc(TSE_FLAGS_OFF, 1);
    wr(TSE_FLAGS_OFF, 0);
    rc(TSE_FLAGS_OFF, 0);
    wr(TSE_CFG_OFF, 32'h0000_0002);
    wr(TSE_TRIG_OFF, 32'h0000_0001);
    rc(TSE_FLAGS_OFF, 0);
    wr(TSE_CFG_OFF, 32'h0000_0001);
    @(posedge clk_i) trigger_reinit_i <= 1;
    @(posedge clk_i) trigger_reinit_i <= 0;
    rc(TSE_FLAGS_OFF, 0);
    wr(TSE_CFG_OFF, 0);
    @(posedge clk_i) trigger_reinit_i <= 1;
    @(posedge clk_i) trigger_reinit_i <= 0;
    rc(TSE_FLAGS_OFF, 1);
    wr(TSE_FLAGS_OFF, 0);
  endtask
  task automatic s_wrap;
    chk({16'h0, counter_load_value_o}, 0);
    @(posedge clk_i) rep_zero_i <= 1;
    @(posedge clk_i) counter_wrap_i <= 1;
    @(posedge clk_i) counter_wrap_i <= 0;
    rc(TSE_FLAGS_OFF, 32'h0000_001d);
    wr(TSE_FLAGS_OFF, 0);
    rep_zero_i <= 0;
    @(posedge clk_i) counter_wrap_i <= 1;
    @(posedge clk_i) counter_wrap_i <= 0;
    rc(TSE_FLAGS_OFF, 32'h0000_001c);
    wr(TSE_FLAGS_OFF, 0);
    @(posedge clk_i) counter_value_i <= 16'h0005;
    @(posedge clk_i) counter_value_i <= 0;
    rc(TSE_FLAGS_OFF, 32'h0000_0002);
    @(posedge clk_i) counter_value_i <= 16'h0005;
    wr(TSE_FLAGS_OFF, 0);
    rc(TSE_FLAGS_OFF, 32'h0000_0002);
    @(posedge clk_i) counter_value_i <= 0;
    wr(TSE_FLAGS_OFF, 0);
  endtask
  task automatic s_events;
    slave_enable_i <= 1;
    @(posedge clk_i) slave_trigger_input_i <= 1;
    wait_n(6);
    wr(TSE_FLAGS_OFF, 0);
    @(posedge clk_i) slave_trigger_input_i <= 0;
    rc(TSE_FLAGS_OFF, 0);
    gated_mode_i <= 1;
    @(posedge clk_i) slave_trigger_input_i <= 1;
    wait_n(4);
    rc(TSE_FLAGS_OFF, 32'h0000_0040);
    @(posedge clk_i) break_active_i <= 1;
    @(posedge clk_i) commutation_event_i <= 1;
    @(posedge clk_i) commutation_event_i <= 0;
    wait_n(4);
    rc(TSE_FLAGS_OFF, 32'h0000_00e0);
    wr(TSE_FLAGS_OFF, 0);
    rc(TSE_FLAGS_OFF, 32'h0000_0080);
    @(posedge clk_i) break_active_i <= 0;
    wait_n(6);
    wr(TSE_FLAGS_OFF, 0);
    wr(TSE_CFG_OFF, 32'h0000_0008);
    wr(TSE_TRIG_OFF, 32'h0000_00e0);
    @(negedge clk_i);
    chk({31'h0, commutation_apply_o}, 1);
    rc(TSE_FLAGS_OFF, 32'h0000_00e0);
    wr(TSE_FLAGS_OFF, 0);
  endtask
  task automatic s_capture;
    wr(TSE_CFG_OFF, 32'h0000_00f0);
    repeat (2) begin
      @(posedge clk_i) capture_event_i <= 4'h1;
      @(posedge clk_i) capture_event_i <= 0;
      wait_n(3);
    end
    rc(TSE_FLAGS_OFF, 32'h0000_0202);
    @(posedge clk_i) capture_read_i <= 4'h1;
    @(posedge clk_i) capture_read_i <= 0;
    rc(TSE_FLAGS_OFF, 32'h0000_0200);
    wr(TSE_TRIG_OFF, 32'h0000_0004);
    @(negedge clk_i);
    chk({28'h0, chan_capture_strobe_o}, 32'h0000_0002);
    wr(TSE_TRIG_OFF, 32'h0000_0004);
    rc(TSE_FLAGS_OFF, 32'h0000_0604);
  endtask
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 0;
    s_update;
    s_wrap;
    s_events;
    s_capture;
    complete_run;
  end
endmodule // tse_core_tb_top
bind tse_core tse_monitor i_mon (.*);

// ---- testbench/tse_monitor.sv ----
// assertion checker for the timer status and event block
`timescale 1ns/1ps
module tse_monitor
  import tse_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic s_axi_wvalid_i,
  input wire logic s_axi_wready_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic main_output_enable_clr_o,
  input wire logic update_force_o,
  input wire logic counter_load_o,
  input wire logic prescaler_clear_o,
  input wire logic [31:0] irq_enable_o,
  input wire logic irq_o,
  input wire logic [6:0] dma_req_o
);
  // event register write taken with both channels in one cycle
  wire ev_wr = s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o
    && s_axi_awaddr_i == TSE_TRIG_OFF;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  bvalid_hold_a: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o)
    else $error("write response dropped before taken");
  rvalid_hold_a: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o)
    else $error("read response dropped before taken");
  upd_force_a: assert property (ev_wr && s_axi_wdata_i[0] |-> ##[1:4] update_force_o)
    else $error("update force did not fire");
  upd_effect_a: assert property (update_force_o |-> counter_load_o && prescaler_clear_o)
    else $error("update force without counter load or prescaler clear");
  brk_force_a: assert property (ev_wr && s_axi_wdata_i[7] |-> ##[1:4] main_output_enable_clr_o)
    else $error("break force did not clear main output enable");
  irq_mask_a: assert property (irq_enable_o[7:0] == 8'h00 |-> !irq_o)
    else $error("interrupt raised while all enables clear");
  dma_mask_a: assert property (irq_enable_o[14:8] == 7'h00 |-> dma_req_o == 7'h00)
    else $error("dma request raised while all enables clear");
  trig_read_a: assert property (s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i ==
    TSE_TRIG_OFF |=> s_axi_rvalid_o && s_axi_rdata_o == 32'h0000_0000)
    else $error("event register read not zero");
endmodule // tse_monitor
